// [hw/fivs_vector_select.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Two-bit field: 00 off, then levels 0-2
// - Converter A zero-cross level in bits 7..6
// - Converter B zero-cross level in bits 5..4
// - Converter A done level in bits 3..2
// - Converter B done level in bits 1..0
// - Base bits 12..0 form vector upper bits
// - Low eight bits come from winning request
// - Unused upper bits read zero, ignore writes, except priority bits 15..8
// - Fast select zero names fast request 0
// - Fast select one names fast request 1
// - Fast request vectors straight to its address
// - Fast requests beat every other level-2 request
// - Fast zero served before fast one
// - Fast zero vector is high5 over low16
// - Fast one vector is high5 over low16
// - Fast one high bits 4..0, rest zero
module fivs_vector_select
    import fivs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] conv_req,
    input wire logic ext_req_valid,
    input wire logic [6:0] ext_req_number,
    input wire logic [1:0] ext_req_level,
    output logic [20:0] vector_address_bus,
    output logic core_irq,
    output logic [1:0] core_irq_level
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [15:0] priority_ninth_reg; // Converter priority fields
    logic [15:0] vector_table_base_reg; // Jump table base
    logic [15:0] fast_select_zero_reg; // Vector number of fast 0
    logic [15:0] fast_select_one_reg; // Vector number of fast 1
    logic [15:0] fast_zero_vector_low_reg;
    logic [15:0] fast_zero_vector_high_reg;
    logic [15:0] fast_one_vector_low_reg;
    logic [15:0] fast_one_vector_high_reg;
    logic [15:0] status_reg; // Last decision, read only
    logic [6:0] win_number_reg; // Number of the presented request

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    logic aw_held_reg; // Write address captured
    logic [5:0] aw_idx_reg; // Captured word index
    logic w_held_reg; // Write data captured
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic do_write; // Both halves present, response free

    // ****************************************************************
    // Arbitration signals
    // ****************************************************************
    logic cand_valid [5]; // Four converter requests then the external winner
    logic [6:0] cand_num [5];
    logic [1:0] cand_lvl [5];
    logic [1:0] best_level;
    logic [6:0] best_num;
    logic fast0_hit;
    logic fast1_hit;
    logic [20:0] vector_next;
    logic irq_next;
    logic [1:0] level_next;
    logic [6:0] number_next;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Merge byte lanes 0 and 1 under the writable mask; upper lanes have no bits
    function automatic logic [15:0] fivs_merge(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] val;
        val = old;
        if (strb[0]) begin
            val[7:0] = data[7:0];
        end
        if (strb[1]) begin
            val[15:8] = data[15:8];
        end
        return val & mask;
    endfunction

    // Level code of one converter field; the code order is the rank order
    function automatic logic [1:0] fivs_field(input logic [15:0] prio, input int lsb);
        return prio[lsb +: 2];
    endfunction

    // Mapped check for a word index
    function automatic logic fivs_mapped(input logic [5:0] idx);
        if (idx == FIVS_IDX_PRIO9) begin
            return 1'b1;
        end else if (idx >= FIVS_IDX_VBASE && idx <= FIVS_IDX_FHIGH1) begin
            return 1'b1;
        end else if (idx == FIVS_IDX_STATUS) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // ****************************************************************
    // Write channel acceptance
    // ****************************************************************
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Address half, taken independently of the data half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[7:2];
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Data half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response; unmapped words answer with a slave error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= FIVS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= fivs_mapped(aw_idx_reg) ? FIVS_RESP_OKAY : FIVS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Writes to the status word are dropped silently: it only mirrors hardware
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            priority_ninth_reg <= FIVS_RESET_VAL;
            vector_table_base_reg <= FIVS_RESET_VAL;
            fast_select_zero_reg <= FIVS_RESET_VAL;
            fast_select_one_reg <= FIVS_RESET_VAL;
            fast_zero_vector_low_reg <= FIVS_RESET_VAL;
            fast_zero_vector_high_reg <= FIVS_RESET_VAL;
            fast_one_vector_low_reg <= FIVS_RESET_VAL;
            fast_one_vector_high_reg <= FIVS_RESET_VAL;
        end else if (do_write) begin
            if (aw_idx_reg == FIVS_IDX_PRIO9) begin
                // Holds fields of
                priority_ninth_reg <= fivs_merge(priority_ninth_reg, w_data_reg, w_strb_reg, FIVS_MASK_PRIO9);
            end else if (aw_idx_reg == FIVS_IDX_VBASE) begin
                vector_table_base_reg <= fivs_merge(vector_table_base_reg, w_data_reg, w_strb_reg,
                                                    FIVS_MASK_VBASE);
            end else if (aw_idx_reg == FIVS_IDX_FSEL0) begin
                fast_select_zero_reg <= fivs_merge(fast_select_zero_reg, w_data_reg, w_strb_reg,
                                                   FIVS_MASK_FSEL);
            end else if (aw_idx_reg == FIVS_IDX_FLOW0) begin
                fast_zero_vector_low_reg <= fivs_merge(fast_zero_vector_low_reg, w_data_reg, w_strb_reg,
                                                       FIVS_MASK_FLOW);
            end else if (aw_idx_reg == FIVS_IDX_FHIGH0) begin
                fast_zero_vector_high_reg <= fivs_merge(fast_zero_vector_high_reg, w_data_reg, w_strb_reg,
                                                        FIVS_MASK_FHIGH);
            end else if (aw_idx_reg == FIVS_IDX_FSEL1) begin
                fast_select_one_reg <= fivs_merge(fast_select_one_reg, w_data_reg, w_strb_reg,
                                                  FIVS_MASK_FSEL);
            end else if (aw_idx_reg == FIVS_IDX_FLOW1) begin
                fast_one_vector_low_reg <= fivs_merge(fast_one_vector_low_reg, w_data_reg, w_strb_reg,
                                                      FIVS_MASK_FLOW);
            end else if (aw_idx_reg == FIVS_IDX_FHIGH1) begin
                fast_one_vector_high_reg <= fivs_merge(fast_one_vector_high_reg, w_data_reg, w_strb_reg,
                                                       FIVS_MASK_FHIGH);
            end
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // One read at a time; data is registered and stands until rready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= FIVS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= FIVS_RESP_OKAY;
            if (s_axi_araddr[7:2] == FIVS_IDX_PRIO9) begin
                rdata_reg <= {16'h0000, priority_ninth_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_VBASE) begin
                rdata_reg <= {16'h0000, vector_table_base_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FSEL0) begin
                rdata_reg <= {16'h0000, fast_select_zero_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FLOW0) begin
                rdata_reg <= {16'h0000, fast_zero_vector_low_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FHIGH0) begin
                rdata_reg <= {16'h0000, fast_zero_vector_high_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FSEL1) begin
                rdata_reg <= {16'h0000, fast_select_one_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FLOW1) begin
                rdata_reg <= {16'h0000, fast_one_vector_low_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_FHIGH1) begin
                rdata_reg <= {16'h0000, fast_one_vector_high_reg};
            end else if (s_axi_araddr[7:2] == FIVS_IDX_STATUS) begin
                rdata_reg <= {16'h0000, status_reg};
            end else begin
                // Unmapped word reads zero with an error
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= FIVS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Candidate gathering
    // ****************************************************************
    // Converter requests first, so they win ties against the external winner
    always_comb begin
        cand_valid[0] = conv_req[3];
        cand_num[0] = FIVS_VEC_A_ZC;
        cand_lvl[0] = fivs_field(priority_ninth_reg, FIVS_LSB_A_ZC);
        cand_valid[1] = conv_req[2];
        cand_num[1] = FIVS_VEC_B_ZC;
        cand_lvl[1] = fivs_field(priority_ninth_reg, FIVS_LSB_B_ZC);
        cand_valid[2] = conv_req[1];
        cand_num[2] = FIVS_VEC_A_DONE;
        cand_lvl[2] = fivs_field(priority_ninth_reg, FIVS_LSB_A_DONE);
        cand_valid[3] = conv_req[0];
        cand_num[3] = FIVS_VEC_B_DONE;
        cand_lvl[3] = fivs_field(priority_ninth_reg, FIVS_LSB_B_DONE);
        cand_valid[4] = ext_req_valid;
        cand_num[4] = ext_req_number;
        cand_lvl[4] = ext_req_level;
    end

    // ****************************************************************
    // Priority and fast-interrupt selection
    // ****************************************************************
    // A fast match outranks any level; level 2 is assumed programmed by software
    always_comb begin
        best_level = FIVS_LVL_OFF;
        best_num = 7'h00;
        fast0_hit = 1'b0;
        fast1_hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (cand_valid[i] && cand_lvl[i] != FIVS_LVL_OFF) begin
                if (cand_num[i] == fast_select_zero_reg[6:0]) begin
                    fast0_hit = 1'b1;
                end
                if (cand_num[i] == fast_select_one_reg[6:0]) begin
                    fast1_hit = 1'b1;
                end
                if (cand_lvl[i] > best_level) begin
                    best_level = cand_lvl[i];
                    best_num = cand_num[i];
                end
            end
        end
    end

    // Form the vector for the winner
    always_comb begin
        irq_next = 1'b1;
        level_next = best_level;
        number_next = best_num;
        if (fast0_hit) begin
            // Fast zero first when both match
            vector_next = {fast_zero_vector_high_reg[4:0], fast_zero_vector_low_reg};
            level_next = FIVS_LVL_2;
            number_next = fast_select_zero_reg[6:0];
        end else if (fast1_hit) begin
            vector_next = {fast_one_vector_high_reg[4:0], fast_one_vector_low_reg};
            level_next = FIVS_LVL_2;
            number_next = fast_select_one_reg[6:0];
        end else if (best_level != FIVS_LVL_OFF) begin
            // Jump table entry: base above, vector number times two below
            vector_next = {vector_table_base_reg[12:0], best_num, 1'b0};
        end else begin
            vector_next = 21'h00_0000;
            irq_next = 1'b0;
        end
    end

    // ****************************************************************
    // Core-facing outputs
    // ****************************************************************
    // Registered to keep the vector glitch free toward the core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vector_address_bus <= 21'h00_0000;
            core_irq <= 1'b0;
            core_irq_level <= FIVS_LVL_OFF;
            win_number_reg <= 7'h00;
        end else begin
            vector_address_bus <= vector_next;
            core_irq <= irq_next;
            core_irq_level <= level_next;
            win_number_reg <= number_next;
        end
    end

    // Status mirror of the presented decision
    always_comb begin
        status_reg = 16'h0000;
        status_reg[FIVS_ST_ACTIVE] = core_irq;
        status_reg[FIVS_ST_LVL_LSB +: 2] = core_irq_level;
        status_reg[FIVS_ST_FAST0] = core_irq && win_number_reg == fast_select_zero_reg[6:0];
        status_reg[FIVS_ST_FAST1] = core_irq && win_number_reg == fast_select_one_reg[6:0] &&
                                    win_number_reg != fast_select_zero_reg[6:0];
        status_reg[6:0] = win_number_reg;
    end

endmodule

// [hw/fivs_pkg.sv]
// ****************************************************************
// Constants for the vector select block
// ****************************************************************
package fivs_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] FIVS_IDX_PRIO9 = 6'h09; // Priority ninth register
    localparam logic [5:0] FIVS_IDX_VBASE = 6'h0a; // Vector table base
    localparam logic [5:0] FIVS_IDX_FSEL0 = 6'h0b; // Fast select zero
    localparam logic [5:0] FIVS_IDX_FLOW0 = 6'h0c; // Fast zero vector low
    localparam logic [5:0] FIVS_IDX_FHIGH0 = 6'h0d; // Fast zero vector high
    localparam logic [5:0] FIVS_IDX_FSEL1 = 6'h0e; // Fast select one
    localparam logic [5:0] FIVS_IDX_FLOW1 = 6'h0f; // Fast one vector low
    localparam logic [5:0] FIVS_IDX_FHIGH1 = 6'h10; // Fast one vector high
    localparam logic [5:0] FIVS_IDX_STATUS = 6'h17; // Vector status, read only

    // ****************************************************************
    // Writable bit masks and reset values
    // ****************************************************************
    localparam logic [15:0] FIVS_MASK_PRIO9 = 16'hffff;
    localparam logic [15:0] FIVS_MASK_VBASE = 16'h1fff; // Bits 15..13 read zero
    localparam logic [15:0] FIVS_MASK_FSEL = 16'h007f; // Bits 15..7 read zero
    localparam logic [15:0] FIVS_MASK_FLOW = 16'hffff;
    localparam logic [15:0] FIVS_MASK_FHIGH = 16'h001f; // Bits 15..5 read zero
    localparam logic [15:0] FIVS_RESET_VAL = 16'h0000; // Every register resets to zero

    // ****************************************************************
    // Priority field positions and level codes
    // ****************************************************************
    localparam int FIVS_LSB_A_ZC = 6; // Converter A zero crossing, bits 7..6
    localparam int FIVS_LSB_B_ZC = 4; // Converter B zero crossing, bits 5..4
    localparam int FIVS_LSB_A_DONE = 2; // Converter A done, bits 3..2
    localparam int FIVS_LSB_B_DONE = 0; // Converter B done, bits 1..0
    localparam logic [1:0] FIVS_LVL_OFF = 2'h0; // Request disabled
    localparam logic [1:0] FIVS_LVL_0 = 2'h1;
    localparam logic [1:0] FIVS_LVL_1 = 2'h2;
    localparam logic [1:0] FIVS_LVL_2 = 2'h3; // Highest available level

    // ****************************************************************
    // Vector numbers of the four converter requests (arbitrary values)
    // ****************************************************************
    localparam logic [6:0] FIVS_VEC_A_ZC = 7'h40;
    localparam logic [6:0] FIVS_VEC_B_ZC = 7'h41;
    localparam logic [6:0] FIVS_VEC_A_DONE = 7'h42;
    localparam logic [6:0] FIVS_VEC_B_DONE = 7'h43;

    // ****************************************************************
    // Status register fields and bus responses
    // ****************************************************************
    localparam int FIVS_ST_ACTIVE = 15; // Request presented to core
    localparam int FIVS_ST_FAST0 = 9; // Fast zero chosen
    localparam int FIVS_ST_FAST1 = 8; // Fast one chosen
    localparam int FIVS_ST_LVL_LSB = 12; // Level code, bits 13..12
    localparam logic [1:0] FIVS_RESP_OKAY = 2'h0;
    localparam logic [1:0] FIVS_RESP_SLVERR = 2'h2;

endpackage

// [testbench/fivs_vector_select_props.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the vector select block
// ****************************************************************
module fivs_vector_select_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] conv_req,
    input wire logic ext_req_valid,
    input wire logic [1:0] ext_req_level,
    input wire logic core_irq,
    input wire logic [1:0] core_irq_level
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    a_idle_no_irq: assert property (conv_req == 4'h0 && !ext_req_valid |=> !core_irq)
        else $error("request shown with nothing raised");
    a_off_ext_drop: assert property (conv_req == 4'h0 && ext_req_valid && ext_req_level == 2'h0 |=> !core_irq)
        else $error("disabled request reached the core");
    a_top_level_pass: assert property (conv_req == 4'h0 && ext_req_valid && ext_req_level == 2'h3
        |=> core_irq && core_irq_level == 2'h3)
        else $error("level two request not presented");
    a_mid_level_pass: assert property (conv_req == 4'h0 && ext_req_valid && ext_req_level == 2'h2
        |=> core_irq && core_irq_level inside {2'h2, 2'h3})
        else $error("level one request not presented");
    a_level_nonzero: assert property (core_irq |-> core_irq_level != 2'h0)
        else $error("request presented with disabled level");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule

// [testbench/fivs_core_model.sv]
`timescale 1ns/1ps
// Core side: fetches each newly raised vector once, as the core would
module fivs_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic core_irq,
    input wire logic [1:0] core_irq_level,
    input wire logic [20:0] vector_address_bus,
    output logic taken,
    output logic [22:0] seen
);
    logic irq_reg; // Request state one cycle ago
    // A steady request is one service call, so only a rise counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
            taken <= 1'b0;
            seen <= 23'h000000;
        end else begin
            irq_reg <= core_irq;
            taken <= core_irq && !irq_reg;
            seen <= {core_irq_level, vector_address_bus};
        end
    end
endmodule

// [testbench/fivs_vector_select_tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the vector select block
// ****************************************************************
module fivs_vector_select_tb_top;
    import fivs_pkg::*;
    logic clk = '0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0, conv_req = '0;
    logic ext_req_valid = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_irq, taken;
    logic [6:0] ext_req_number = '0;
    logic [1:0] ext_req_level = '0, s_axi_bresp, s_axi_rresp, core_irq_level;
    logic [20:0] vector_address_bus;
    logic [22:0] seen;
    logic [33:0] exp_q[$]; // Expected read answers, oldest first
    logic [22:0] vec_q[$]; // Expected vector fetches
    int n_mismatch = 0, compares = 0, seed = 32'h4bf2;
    logic [5:0] idx[8] = '{FIVS_IDX_PRIO9, FIVS_IDX_VBASE, FIVS_IDX_FSEL0, FIVS_IDX_FLOW0,
        FIVS_IDX_FHIGH0, FIVS_IDX_FSEL1, FIVS_IDX_FLOW1, FIVS_IDX_FHIGH1};
    logic [15:0] msk[8] = '{FIVS_MASK_PRIO9, FIVS_MASK_VBASE, FIVS_MASK_FSEL, FIVS_MASK_FLOW,
        FIVS_MASK_FHIGH, FIVS_MASK_FSEL, FIVS_MASK_FLOW, FIVS_MASK_FHIGH};
    logic [15:0] val[8]; // Register contents as software left them
    always #5 clk = ~clk;
    fivs_vector_select fivs_vector_select_inst (.*);
    fivs_core_model fivs_core_model_inst (.*);

    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Results are matched against the oldest note; negedge avoids edge races
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (taken) chk("vector", vec_q.pop_front(), seen);
    end
    // Readies are sampled mid-cycle; they only change after a rising edge
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
        logic aw, w, b;
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            if (b) chk("bresp", er, s_axi_bresp);
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
        logic g, r;
        exp_q.push_back({er, 16'h0000, d});
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            g = s_axi_arready;
            r = s_axi_rvalid;
            @(posedge clk);
            if (g) s_axi_arvalid <= 1'b0;
        end while (!r);
    endtask
    // Raise requests, expect one fetch (or none when e is zero), then drop
    task automatic fire(input logic [3:0] c, input logic ev, input logic [6:0] n, input logic [1:0] l,
        input logic [22:0] e);
        conv_req <= c;
        ext_req_valid <= ev;
        ext_req_number <= n;
        ext_req_level <= l;
        if (e != 23'h0) vec_q.push_back(e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        if (e == 23'h0) chk("irq", 1'b0, core_irq);
        @(posedge clk);
        conv_req <= 4'h0;
        ext_req_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic end_of_test();
        if (exp_q.size() + vec_q.size() != 0) n_mismatch++; // Notes never answered
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        logic [15:0] d;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (idx[i]) rd(idx[i], FIVS_RESET_VAL, FIVS_RESP_OKAY);
        rd(6'h3f, 16'h0000, FIVS_RESP_SLVERR);
        wr(6'h3f, 16'hffff, FIVS_RESP_SLVERR);
        foreach (idx[i]) begin
            d = 16'($random(seed));
            val[i] = d & msk[i];
            wr(idx[i], d, FIVS_RESP_OKAY);
            rd(idx[i], val[i], FIVS_RESP_OKAY);
        end
        $display("Register test done");
        wr(FIVS_IDX_FSEL0, 16'h007f, FIVS_RESP_OKAY);
        wr(FIVS_IDX_FSEL1, 16'h007e, FIVS_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                wr(FIVS_IDX_PRIO9, 16'(c << (6 - 2 * i)), FIVS_RESP_OKAY);
                fire(4'(8 >> i), 1'b0, 7'h00, 2'h0, c == 0 ? 23'h0 : {2'(c), val[1][12:0], 7'h40 + 7'(i), 1'b0});
            end
        end
        for (int c = 0; c < 4; c++) fire(4'h0, 1'b1, 7'h20, 2'(c), c == 0 ? 23'h0 : {2'(c), val[1][12:0], 7'h20, 1'b0});
        $display("Level test done");
        wr(FIVS_IDX_PRIO9, 16'h00ff, FIVS_RESP_OKAY);
        wr(FIVS_IDX_FSEL0, 16'h0042, FIVS_RESP_OKAY);
        wr(FIVS_IDX_FSEL1, 16'h0041, FIVS_RESP_OKAY);
        fire(4'hf, 1'b1, 7'h40, 2'h3, {2'h3, val[4][4:0], val[3]});
        fire(4'h8, 1'b1, 7'h41, 2'h3, {2'h3, val[7][4:0], val[6]});
        conv_req <= 4'h2; // Fast zero held up while status is read
        vec_q.push_back({2'h3, val[4][4:0], val[3]});
        @(posedge clk);
        rd(FIVS_IDX_STATUS, 16'hb242, FIVS_RESP_OKAY);
        conv_req <= 4'h0;
        wr(FIVS_IDX_PRIO9, 16'h00f3, FIVS_RESP_OKAY);
        fire(4'h2, 1'b0, 7'h00, 2'h0, 23'h0);
        $display("Fast test done");
        end_of_test();
    end
endmodule

bind fivs_vector_select fivs_vector_select_props fivs_vector_select_props_inst (.*);
